/* sss_consts.svh */
// constants for the subtract / swap / skip execution block
// assumes an APB slave with 32-bit data and word-aligned registers
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH

// register byte offsets
`define SSS_OFF_INSTR 12'h000
`define SSS_OFF_ACC 12'h004
`define SSS_OFF_FLAGS 12'h008
`define SSS_OFF_PC 12'h00c
`define SSS_OFF_MEM_LO 12'h040
`define SSS_OFF_MEM_HI 12'h07c

// instruction word fields
`define SSS_INSTR_OP_LSB 0
`define SSS_INSTR_ADDR_LSB 8
`define SSS_INSTR_IMM_LSB 16
`define SSS_INSTR_BIT_LSB 24

// flag register bit positions
`define SSS_FLAG_C 0
`define SSS_FLAG_AUX_CARRY 1
`define SSS_FLAG_Z 2
`define SSS_FLAG_OVERFLOW 3
`define SSS_FLAG_SIGNED_CARRY 4
`define SSS_FLAG_ZERO_CARRY 5

// pc register: skip-pending bit
`define SSS_PC_SKIP_BIT 16

// reset values
`define SSS_ACC_RST 8'h00
`define SSS_FLAGS_RST 6'h00
`define SSS_PC_RST 16'h0000

// data memory size in bytes
`define SSS_MEM_DEPTH 16

`endif

/* sss_pkg.sv */
// types for the subtract / swap / skip execution block
// assumes sss_consts.svh holds all offsets and field positions
package sss_pkg;

	typedef enum logic [3:0] {
		SSS_OP_NOP = 4'h0,
		SSS_OP_SUB_TO_MEMORY = 4'h1,
		SSS_OP_SUB_IMM = 4'h2,
		SSS_OP_NIBBLE_EXCHANGE = 4'h3,
		SSS_OP_NIBBLE_EXCHANGE_TO_ACC = 4'h4,
		SSS_OP_SKIP_WHEN_ZERO = 4'h5,
		SSS_OP_SKIP_WHEN_ZERO_MOVE = 4'h6,
		SSS_OP_SKIP_BIT_ZERO = 4'h7
	} sss_op_t;

	typedef enum logic [1:0] {
		SSS_ST_IDLE = 2'b00,
		SSS_ST_EXEC = 2'b01,
		SSS_ST_DUMMY = 2'b10,
		SSS_ST_DONE = 2'b11
	} sss_state_t;

endpackage : sss_pkg

/* sss_sub_unit.sv */
// 8-bit subtractor with status flag generation
// purely combinational; the caller registers the results
`timescale 1ns/1ps
`default_nettype none

module sss_sub_unit (
	input wire logic [7:0] minuend,
	input wire logic [7:0] subtrahend,
	output logic [7:0] diff,
	output logic carry,
	output logic aux_carry,
	output logic zero,
	output logic overflow,
	output logic signed_carry,
	output logic zero_carry
);
	logic [8:0] wide_diff;
	logic [4:0] low_diff;

	assign wide_diff = {1'b0, minuend} - {1'b0, subtrahend};
	assign low_diff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
	assign diff = wide_diff[7:0];
	// carry means no borrow: a negative difference clears it
	assign carry = ~wide_diff[8];
	assign aux_carry = ~low_diff[4];
	assign zero = (wide_diff[7:0] == 8'h00);
	assign overflow = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ wide_diff[7]);
	// signed no-borrow: true sign of the signed difference, inverted
	assign signed_carry = ~(overflow ^ wide_diff[7]);
	assign zero_carry = zero;

endmodule : sss_sub_unit

`default_nettype wire

/* sss_exec.sv */
// execution block: subtract, nibble swap and skip-on-zero instructions
// instructions arrive as APB writes; data memory and accumulator live here
`timescale 1ns/1ps
`default_nettype none
`include "sss_consts.svh"

// How it works
// - sub_to_memory writes accumulator minus memory byte to memory, accumulator kept.
// - after subtraction carry is 0 for a negative difference, else 1.
// - both subtractions update overflow, zero, aux carry, carry, signed and zero carry.
// - subtract immediate puts accumulator minus immediate into the accumulator.
// - in-place swap exchanges memory nibbles, writes back, flags untouched.
// - swap to accumulator loads swapped memory byte into accumulator only.
// - skip_when_zero skips the next instruction when the memory byte is zero.
// - every skip-type instruction that is not itself discarded takes two instruction cycles; a discarded one takes one.
// - skip_when_zero_move copies the byte to accumulator, skips if zero, no flags.
// - bit-test skip skips the next instruction when the chosen bit is zero.
module sss_exec import sss_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	sss_state_t state;
	sss_state_t next_state;
	logic [31:0] instr;
	logic [7:0] accumulator_reg;
	logic [5:0] flags;
	logic [15:0] pc;
	logic skip_pend;
	logic [7:0] mem [0:`SSS_MEM_DEPTH-1];

	// address decode
	wire sel_instr = (paddr == `SSS_OFF_INSTR);
	wire sel_acc = (paddr == `SSS_OFF_ACC);
	wire sel_flags = (paddr == `SSS_OFF_FLAGS);
	wire sel_pc = (paddr == `SSS_OFF_PC);
	wire sel_mem = (paddr >= `SSS_OFF_MEM_LO) && (paddr <= `SSS_OFF_MEM_HI) && (paddr[1:0] == 2'b00);
	wire [3:0] bus_mem_idx = paddr[5:2];
	wire mapped = sel_instr | sel_acc | sel_flags | sel_pc | sel_mem;
	wire access = psel & penable;
	wire instr_req = access & pwrite & sel_instr;
	// instruction writes stall the bus until execution has finished
	assign pready = instr_req ? (state == SSS_ST_DONE) : 1'b1;
	assign pslverr = access & ~mapped;
	wire bus_wr = access & pwrite & pready & mapped & ~sel_instr & ~sel_pc;

	// instruction fields
	wire [3:0] op = instr[`SSS_INSTR_OP_LSB +: 4];
	wire [3:0] m_idx = instr[`SSS_INSTR_ADDR_LSB +: 4];
	wire [7:0] imm = instr[`SSS_INSTR_IMM_LSB +: 8];
	wire [2:0] bit_idx = instr[`SSS_INSTR_BIT_LSB +: 3];
	wire [7:0] m_val = mem[m_idx];
	wire [7:0] m_swapped = {m_val[3:0], m_val[7:4]};

	wire is_sub_mem = (op == SSS_OP_SUB_TO_MEMORY);
	wire is_subi = (op == SSS_OP_SUB_IMM);
	wire is_swap = (op == SSS_OP_NIBBLE_EXCHANGE);
	wire is_swap_acc = (op == SSS_OP_NIBBLE_EXCHANGE_TO_ACC);
	wire is_skip_zero = (op == SSS_OP_SKIP_WHEN_ZERO);
	wire is_skip_move = (op == SSS_OP_SKIP_WHEN_ZERO_MOVE);
	wire is_skip_bit = (op == SSS_OP_SKIP_BIT_ZERO);
	wire is_skip_type = is_skip_zero | is_skip_move | is_skip_bit;
	wire is_sub = is_sub_mem | is_subi;

	// a discarded instruction still walks the cycle but has no effect
	wire live = (state == SSS_ST_EXEC) & ~skip_pend;
	wire skip_cond = (is_skip_zero & (m_val == 8'h00))
		| (is_skip_move & (m_val == 8'h00))
		| (is_skip_bit & ~m_val[bit_idx]);

	wire [7:0] sub_operand = is_subi ? imm : m_val;
	wire [7:0] sub_diff;
	wire [5:0] sub_flags;

	sss_sub_unit sss_sub_unit_inst (
		.minuend(accumulator_reg),
		.subtrahend(sub_operand),
		.diff(sub_diff),
		.carry(sub_flags[`SSS_FLAG_C]),
		.aux_carry(sub_flags[`SSS_FLAG_AUX_CARRY]),
		.zero(sub_flags[`SSS_FLAG_Z]),
		.overflow(sub_flags[`SSS_FLAG_OVERFLOW]),
		.signed_carry(sub_flags[`SSS_FLAG_SIGNED_CARRY]),
		.zero_carry(sub_flags[`SSS_FLAG_ZERO_CARRY])
	);

	// next values of the architectural state
	wire mem_exec_wr = live & (is_sub_mem | is_swap);
	wire [7:0] mem_exec_data = is_sub_mem ? sub_diff : m_swapped;
	wire acc_exec_wr = live & (is_subi | is_swap_acc | is_skip_move);
	wire [7:0] acc_exec_data = is_subi ? sub_diff
		: is_swap_acc ? m_swapped
		: m_val;

	// state machine: skip-type instructions that are not discarded insert a dummy cycle
	always_comb begin
		next_state = state;
		case (state)
			SSS_ST_IDLE: begin
				if (instr_req) begin
					next_state = SSS_ST_EXEC;
				end
			end
			SSS_ST_EXEC: begin
				if (live & is_skip_type) begin
					next_state = SSS_ST_DUMMY;
				end else begin
					next_state = SSS_ST_DONE;
				end
			end
			SSS_ST_DUMMY: begin
				next_state = SSS_ST_DONE;
			end
			SSS_ST_DONE: begin
				next_state = SSS_ST_IDLE;
			end
			default: begin
				next_state = SSS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= SSS_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr <= 32'h0000_0000;
		end else if (instr_req && state == SSS_ST_IDLE) begin
			instr <= pwdata;
		end
	end

	// program counter counts every issued instruction, discarded ones too
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc <= `SSS_PC_RST;
			skip_pend <= 1'b0;
		end else if (state == SSS_ST_EXEC) begin
			pc <= pc + 16'h0001;
			skip_pend <= live & skip_cond;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accumulator_reg <= `SSS_ACC_RST;
		end else if (acc_exec_wr) begin
			accumulator_reg <= acc_exec_data;
		end else if (bus_wr && sel_acc) begin
			accumulator_reg <= pwdata[7:0];
		end
	end

	// only subtraction touches flags; swaps and skips leave them alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= `SSS_FLAGS_RST;
		end else if (live && is_sub) begin
			flags <= sub_flags;
		end else if (bus_wr && sel_flags) begin
			flags <= pwdata[5:0];
		end
	end

	// data memory has no reset; software loads it before use
	always_ff @(posedge pclk) begin
		if (mem_exec_wr) begin
			mem[m_idx] <= mem_exec_data;
		end else if (bus_wr && sel_mem) begin
			mem[bus_mem_idx] <= pwdata[7:0];
		end
	end

	// read data is registered on the setup cycle and held through access
	wire [31:0] rd_mux = sel_instr ? instr
		: sel_acc ? {24'h00_0000, accumulator_reg}
		: sel_flags ? {26'h000_0000, flags}
		: sel_pc ? {15'h0000, skip_pend, pc}
		: sel_mem ? {24'h00_0000, mem[bus_mem_idx]}
		: 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	wire exec_sub_mem = live & is_sub_mem;
	wire exec_sub = live & is_sub;
	wire exec_skip = live & is_skip_type;

	sequence s_dummy_then_done;
		(state == SSS_ST_DUMMY) ##1 (state == SSS_ST_DONE);
	endsequence

	chk_sub_mem_write: assert property (exec_sub_mem |=>
		(mem[$past(m_idx)] == $past(accumulator_reg) - $past(m_val))
		&& $stable(accumulator_reg))
		else $error("subtract to memory result wrong");

	chk_carry_borrow: assert property (exec_sub |=>
		flags[`SSS_FLAG_C] == ($past(accumulator_reg) >= $past(sub_operand)))
		else $error("carry does not reflect sign of difference");

	chk_zero_flags: assert property (exec_sub |=>
		flags[`SSS_FLAG_Z] == ($past(accumulator_reg) == $past(sub_operand))
		&& flags[`SSS_FLAG_ZERO_CARRY] == flags[`SSS_FLAG_Z])
		else $error("zero flags wrong after subtract");

	chk_subi_acc: assert property (live & is_subi |=>
		accumulator_reg == $past(accumulator_reg) - $past(imm))
		else $error("subtract immediate result wrong");

	chk_swap_in_place: assert property (live & is_swap |=>
		mem[$past(m_idx)] == {$past(m_val[3:0]), $past(m_val[7:4])} && $stable(flags))
		else $error("in-place nibble swap wrong");

	chk_swap_to_acc: assert property (live & is_swap_acc |=>
		accumulator_reg == {$past(m_val[3:0]), $past(m_val[7:4])}
		&& $stable(flags) && mem[$past(m_idx)] == $past(m_val))
		else $error("nibble swap to accumulator wrong");

	chk_skip_zero: assert property (live & is_skip_zero |=>
		skip_pend == ($past(m_val) == 8'h00) && $stable(flags))
		else $error("skip when zero decision wrong");

	chk_skip_two_cycles: assert property (exec_skip |=> s_dummy_then_done ##1
		(state == SSS_ST_IDLE))
		else $error("skip instruction not two cycles");

	chk_skip_move: assert property (live & is_skip_move |=>
		accumulator_reg == $past(m_val) && skip_pend == ($past(m_val) == 8'h00)
		&& $stable(flags))
		else $error("skip when zero move wrong");

	chk_bit_skip: assert property (live & is_skip_bit |=>
		skip_pend == ~$past(m_val[bit_idx]))
		else $error("bit test skip decision wrong");

	chk_discard_effect: assert property ((state == SSS_ST_EXEC) & skip_pend |=>
		$stable(accumulator_reg) && $stable(flags) && !skip_pend
		&& pc == $past(pc) + 16'h0001 && mem[$past(m_idx)] == $past(m_val))
		else $error("skipped instruction had an effect");

	// reference values for the flag checks, worked out apart from the subtractor
	wire [7:0] ref_diff = accumulator_reg - sub_operand;
	wire ref_signed_ge = $signed(accumulator_reg) >= $signed(sub_operand);
	wire ref_nibble_ge = accumulator_reg[3:0] >= sub_operand[3:0];

	chk_aux_carry: assert property (exec_sub |=>
		flags[`SSS_FLAG_AUX_CARRY] == $past(ref_nibble_ge))
		else $error("aux carry wrong after subtract");

	chk_overflow_flag: assert property (exec_sub |=>
		flags[`SSS_FLAG_OVERFLOW] == $past((accumulator_reg[7] ^ sub_operand[7])
		& (accumulator_reg[7] ^ ref_diff[7])))
		else $error("overflow wrong after subtract");

	chk_signed_carry: assert property (exec_sub |=>
		flags[`SSS_FLAG_SIGNED_CARRY] == $past(ref_signed_ge))
		else $error("signed carry wrong after subtract");

	chk_sub_diff_value: assert property (exec_sub |-> sub_diff == ref_diff)
		else $error("subtractor difference wrong");

	chk_skip_mem_kept: assert property (exec_skip |=>
		mem[$past(m_idx)] == $past(m_val))
		else $error("skip instruction changed memory");

	chk_ordinary_one_cycle: assert property (live & ~is_skip_type |=>
		state == SSS_ST_DONE)
		else $error("ordinary instruction took a dummy cycle");

	chk_pc_advance: assert property (state == SSS_ST_EXEC |=>
		pc == $past(pc) + 16'h0001)
		else $error("program counter did not advance");

	chk_sub_no_skip: assert property (exec_sub |=> !skip_pend)
		else $error("subtract left a skip pending");

	chk_skip_zero_acc: assert property (live & is_skip_zero |=>
		$stable(accumulator_reg))
		else $error("skip when zero changed the accumulator");

	chk_bit_skip_kept: assert property (live & is_skip_bit |=>
		$stable(accumulator_reg) && $stable(flags))
		else $error("bit test skip changed state");

endmodule : sss_exec

`default_nettype wire

/* tb_top.sv */
// self-checking bench for the subtract / swap / skip execution block
// assumes sss_exec alone, driven over APB from this module, no external model
`timescale 1ns/1ps
`default_nettype none
`include "sss_consts.svh"

module tb_top import sss_pkg::*; ;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] q;
	logic q_err;
	int n;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;

	sss_exec sss_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// the whole run needs a few hundred cycles; this only cuts a hang short
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// pready and prdata are read as the edge arrives, before that edge updates any register
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		q = prdata;
		q_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [11:0] ma(input logic [3:0] i);
		return 12'h040 + {6'h00, i, 2'b00};
	endfunction : ma

	task automatic exec(input logic [3:0] op, input logic [3:0] idx, input logic [7:0] imm,
		input logic [2:0] b);
		apb(1'b1, `SSS_OFF_INSTR, {5'h00, b, imm, 4'h0, idx, 4'h0, op});
	endtask : exec

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		check(q, exp, what);
	endtask : rd_chk

	task automatic t_sub;
		apb(1'b1, ma(4'h2), 32'h30);
		apb(1'b1, `SSS_OFF_ACC, 32'h10);
		exec(SSS_OP_SUB_TO_MEMORY, 4'h2, 8'h00, 3'h0);
		check(n, 3, "ordinary cycles");
		rd_chk(ma(4'h2), 32'he0, "sub mem result");
		rd_chk(`SSS_OFF_ACC, 32'h10, "sub mem acc kept");
		rd_chk(`SSS_OFF_FLAGS, 32'h02, "sub mem flags");
		apb(1'b1, `SSS_OFF_ACC, 32'h80);
		exec(SSS_OP_SUB_IMM, 4'h0, 8'h01, 3'h0);
		rd_chk(`SSS_OFF_ACC, 32'h7f, "sub imm result");
		rd_chk(`SSS_OFF_FLAGS, 32'h09, "sub imm overflow flags");
		apb(1'b1, `SSS_OFF_ACC, 32'h55);
		exec(SSS_OP_SUB_IMM, 4'h0, 8'h55, 3'h0);
		rd_chk(`SSS_OFF_ACC, 32'h00, "sub imm zero");
		rd_chk(`SSS_OFF_FLAGS, 32'h37, "sub imm zero flags");
	endtask : t_sub

	task automatic t_swap;
		apb(1'b1, ma(4'h3), 32'ha5);
		apb(1'b1, `SSS_OFF_FLAGS, 32'h15);
		exec(SSS_OP_NIBBLE_EXCHANGE, 4'h3, 8'h00, 3'h0);
		rd_chk(ma(4'h3), 32'h5a, "swap in place");
		rd_chk(`SSS_OFF_FLAGS, 32'h15, "swap flags kept");
		apb(1'b1, ma(4'h4), 32'h3c);
		exec(SSS_OP_NIBBLE_EXCHANGE_TO_ACC, 4'h4, 8'h00, 3'h0);
		rd_chk(`SSS_OFF_ACC, 32'hc3, "swap to acc");
		rd_chk(ma(4'h4), 32'h3c, "swap to acc mem kept");
		rd_chk(`SSS_OFF_FLAGS, 32'h15, "swap to acc flags kept");
	endtask : t_swap

	// flags hold 0x15 on entry; the follow-up subtract shows whether it was discarded
	task automatic skip_case(input logic [3:0] op, input logic [3:0] idx, input logic [2:0] b,
		input logic [7:0] mv, input logic skip, input logic mov);
		logic [15:0] p0;
		logic [7:0] a0;
		a0 = mov ? mv : 8'h11;
		apb(1'b1, ma(idx), {24'h0, mv});
		apb(1'b1, `SSS_OFF_ACC, 32'h11);
		apb(1'b0, `SSS_OFF_PC, 32'h0);
		p0 = q[15:0];
		exec(op, idx, 8'h00, b);
		check(n, 4, "skip type cycles");
		rd_chk(`SSS_OFF_FLAGS, 32'h15, "skip flags kept");
		rd_chk(`SSS_OFF_ACC, {24'h0, a0}, "skip acc");
		rd_chk(`SSS_OFF_PC, {15'h0, skip, p0 + 16'h1}, "skip pending");
		exec(SSS_OP_SUB_IMM, 4'h0, 8'h01, 3'h0);
		rd_chk(`SSS_OFF_ACC, {24'h0, skip ? a0 : a0 - 8'h01}, "follow-up acc");
		rd_chk(`SSS_OFF_PC, {16'h0, p0 + 16'h2}, "pc past follow-up");
		apb(1'b1, `SSS_OFF_FLAGS, 32'h15);
		rd_chk(ma(idx), {24'h0, mv}, "skip mem kept");
	endtask : skip_case

	task automatic t_unmapped;
		apb(1'b0, 12'h800, 32'h0);
		check({31'h0, q_err}, 32'h1, "unmapped error");
		check(q, 32'h0, "unmapped data");
	endtask : t_unmapped

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`SSS_OFF_ACC, 32'h0, "acc reset");
		rd_chk(`SSS_OFF_FLAGS, 32'h0, "flags reset");
		rd_chk(`SSS_OFF_PC, 32'h0, "pc reset");
		t_sub();
		t_swap();
		skip_case(SSS_OP_SKIP_WHEN_ZERO, 4'h5, 3'h0, 8'h00, 1'b1, 1'b0);
		skip_case(SSS_OP_SKIP_WHEN_ZERO, 4'h5, 3'h0, 8'h01, 1'b0, 1'b0);
		skip_case(SSS_OP_SKIP_WHEN_ZERO_MOVE, 4'h6, 3'h0, 8'h00, 1'b1, 1'b1);
		skip_case(SSS_OP_SKIP_WHEN_ZERO_MOVE, 4'h6, 3'h0, 8'h80, 1'b0, 1'b1);
		skip_case(SSS_OP_SKIP_BIT_ZERO, 4'h7, 3'h3, 8'hf7, 1'b1, 1'b0);
		skip_case(SSS_OP_SKIP_BIT_ZERO, 4'h7, 3'h3, 8'h08, 1'b0, 1'b0);
		t_unmapped();
		stop_test();
	end
endmodule : tb_top

`default_nettype wire
